/* File: shared/hwas_pkg.sv */
// Constants shared by the handwheel axis selector: register map, field layout, reset values.
package hwas_pkg;
  // Byte offsets of the registers on the AXI4-Lite slave.
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_SEL      = 4'h4;
  localparam logic [3:0]  ADDR_STAT     = 4'h8;
  // Control register fields: handle mode enable and number of fitted handwheels.
  localparam int          CTRL_MODE_BIT = 0;
  localparam int          CTRL_CNT_LSB  = 1;
  localparam int          CTRL_CNT_W    = 2;
  localparam logic [31:0] CTRL_MASK     = 32'h0000_0007;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0002;
  // Selection image: per wheel, a 5-bit axis number at its base and a valid bit 7 above it.
  localparam int          WHEELS        = 3;
  localparam int          NUM_W         = 5;
  localparam int          VALID_OFS     = 7;
  localparam int          WHEEL_STRIDE  = 8;
  localparam logic [31:0] SEL_MASK      = 32'h009f_9f9f;
  localparam logic [31:0] SEL_RST       = 32'h0000_0000;
  // Number of axes that can be driven by a handwheel.
  localparam int          AXES          = 8;
  // Status register: wheel active flags sit above the three decoded axis fields.
  localparam int          STAT_ACT_LSB  = 24;
  // AXI response codes.
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
endpackage : hwas_pkg

/* File: src/hwas_selector.sv */
// Handwheel axis selector: decodes per-wheel axis numbers and routes handwheel steps to axes.
//
// Contract
// (RL1) Software selects mode, loads number, sets valid.
// (RL2) Axis number is binary; value n picks axis n.
// (RL3) Valid low means the wheel moves nothing.
// (RL4) Number and valid in any order; both needed.
// (RL5) Second wheel acts like first when two fitted.
// (RL6) Third wheel acts like first when three fitted.
// (RL7) First wheel: number at base, valid bit separate.
// (RL8) Second wheel: number and valid at its positions.
// (RL9) Third wheel: number and valid at its positions.
// (RL10) Outside mode or invalid, selected axis is none.
`timescale 1ns/100ps
`default_nettype none
module hwas_selector
  import hwas_pkg::*;
(
  input  wire logic               clk,           // 200 MHz scan clock.
  input  wire logic               rst_b,         // Asynchronous reset, active low.
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [3:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [WHEELS-1:0]  wheel_step,    // One-cycle pulse per handwheel detent.
  output logic [AXES-1:0]         axis_step,     // One-cycle step pulse per axis.
  output logic [NUM_W-1:0]        wheel1_axis,   // Selected axis of wheel 1, zero is none.
  output logic [NUM_W-1:0]        wheel2_axis,   // Selected axis of wheel 2, zero is none.
  output logic [NUM_W-1:0]        wheel3_axis    // Selected axis of wheel 3, zero is none.
);

  // Software-written control word and selection image.
  logic [31:0]          ctrl_ff;
  logic [31:0]          sel_ff;
  // Write channel holding registers, so address and data may come in either order.
  logic                 aw_hold_ff;
  logic [3:0]           awaddr_ff;
  logic                 w_hold_ff;
  logic [31:0]          wdata_ff;
  logic [3:0]           wstrb_ff;
  logic                 bvalid_ff;
  logic [1:0]           bresp_ff;
  logic                 rvalid_ff;
  logic [31:0]          rdata_ff;
  logic [1:0]           rresp_ff;
  // Decoded selection, live and registered.
  logic [NUM_W-1:0]     nxt_axis [WHEELS];
  logic [NUM_W-1:0]     axis_ff  [WHEELS];
  logic [AXES-1:0]      nxt_axis_step;
  logic [AXES-1:0]      axis_step_ff;
  // Write decode helpers.
  logic                 aw_hs;
  logic                 w_hs;
  logic                 do_write;
  logic [3:0]           wr_addr;
  logic [31:0]          wr_data;
  logic [3:0]           wr_strb;
  logic                 mode_on;
  logic [CTRL_CNT_W-1:0] wheel_cnt;

  // Merges a write into a register under byte strobes and a writable-bit mask.
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res & mask;
  endfunction : merge_strb

  // Turns a wheel's number and valid bit into a 1-based axis, zero when nothing is selected.
  function automatic logic [NUM_W-1:0] axis_decode(input logic [NUM_W-1:0] num,
                                                   input logic valid, input logic mode,
                                                   input logic fitted);
    logic [NUM_W-1:0] res;
    res = '0;
    // (RL2) Binary weights 1..16; only values 1..8 give an axis.
    if (mode && valid && fitted && (num != '0) && (int'(num) <= AXES)) begin
      res = num;
    end
    return res;
  endfunction : axis_decode

  assign mode_on   = ctrl_ff[CTRL_MODE_BIT];
  assign wheel_cnt = ctrl_ff[CTRL_CNT_LSB +: CTRL_CNT_W];

  // Either channel may arrive first; each is refused while its own item is held or a write response is pending.
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign do_write      = (aw_hold_ff || aw_hs) && (w_hold_ff || w_hs) && !bvalid_ff;
  assign wr_addr       = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_data       = w_hold_ff ? wdata_ff : s_axi_wdata;
  assign wr_strb       = w_hold_ff ? wstrb_ff : s_axi_wstrb;

  // Address channel holder, emptied when the write completes.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_ff <= 1'b0;
      awaddr_ff  <= 4'h0;
    end else if (do_write) begin
      aw_hold_ff <= 1'b0;
    end else if (aw_hs) begin
      aw_hold_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end
  end

  // Data channel holder, emptied when the write completes.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_hold_ff <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else if (do_write) begin
      w_hold_ff <= 1'b0;
    end else if (w_hs) begin
      w_hold_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end
  end

  // Register writes; the status word is read-only and a write there is refused.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= CTRL_RST;
      sel_ff  <= SEL_RST;
    end else if (do_write) begin
      if (wr_addr == ADDR_CTRL) begin
        ctrl_ff <= merge_strb(ctrl_ff, wr_data, wr_strb, CTRL_MASK);
      end
      // (RL1) Software loads number and valid.
      if (wr_addr == ADDR_SEL) begin
        sel_ff <= merge_strb(sel_ff, wr_data, wr_strb, SEL_MASK);
      end
    end
  end

  // Write response, held until the master takes it.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_addr == ADDR_CTRL || wr_addr == ADDR_SEL) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;

  // Read data path; unmapped offsets answer with a slave error and zero data.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CTRL: rdata_ff <= ctrl_ff;
        ADDR_SEL:  rdata_ff <= sel_ff;
        ADDR_STAT: begin
          rdata_ff <= {5'h00, axis_ff[2] != '0, axis_ff[1] != '0, axis_ff[0] != '0,
                       3'h0, axis_ff[2], 3'h0, axis_ff[1], 3'h0, axis_ff[0]};
        end
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // Live decode of every wheel; a wheel counts as fitted when its index is below the count.
  always_comb begin
    for (int w = 0; w < WHEELS; w++) begin
      // (RL7) (RL8) (RL9) Fields at wheel positions.
      // (RL3) (RL10) Invalid or no mode gives none.
      // (RL5) (RL6) Extra wheels need fitting.
      nxt_axis[w] = axis_decode(sel_ff[w*WHEEL_STRIDE +: NUM_W],
                                sel_ff[w*WHEEL_STRIDE + VALID_OFS], mode_on,
                                w < int'(wheel_cnt));
    end
  end

  // Step routing uses the live decode so a detent is judged by the selection it meets.
  always_comb begin
    nxt_axis_step = '0;
    for (int w = 0; w < WHEELS; w++) begin
      for (int a = 0; a < AXES; a++) begin
        // (RL4) Both present when motion starts.
        if (wheel_step[w] && (int'(nxt_axis[w]) == a + 1)) begin
          nxt_axis_step[a] = 1'b1;
        end
      end
    end
  end

  // Registered selection and step outputs.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      axis_ff      <= '{default: '0};
      axis_step_ff <= '0;
    end else begin
      axis_ff      <= nxt_axis;
      axis_step_ff <= nxt_axis_step;
    end
  end

  assign axis_step   = axis_step_ff;
  assign wheel1_axis = axis_ff[0];
  assign wheel2_axis = axis_ff[1];
  assign wheel3_axis = axis_ff[2];

  // Checks on the decode and routing.
  mode_gate_a: assert property (@(posedge clk) disable iff (!rst_b) // (RL10)
    !mode_on |=> (wheel1_axis == '0 && wheel2_axis == '0 && wheel3_axis == '0))
    else $error("Axis selected outside handle mode");
  valid_gate_a: assert property (@(posedge clk) disable iff (!rst_b) // (RL3)
    !sel_ff[VALID_OFS] |=> (wheel1_axis == '0) &&
      !($past(wheel_step) == 3'b001 && axis_step != '0))
    else $error("Wheel 1 selects an axis without valid");
  first_decode_a: assert property (@(posedge clk) disable iff (!rst_b) // (RL2)
    (mode_on && wheel_cnt != '0 && sel_ff[VALID_OFS] && sel_ff[4:0] == 5'h03)
      |=> wheel1_axis == 5'h03)
    else $error("Wheel 1 number 3 not decoded as third axis");
  first_field_a: assert property (@(posedge clk) disable iff (!rst_b) // (RL7)
    (mode_on && wheel_cnt != '0 && sel_ff[VALID_OFS] && sel_ff[4:0] != '0 &&
     sel_ff[4:0] <= 5'h08) |=> wheel1_axis == $past(sel_ff[4:0]))
    else $error("Wheel 1 field not taken from its base");
  second_fit_a: assert property (@(posedge clk) disable iff (!rst_b) // (RL5)
    (wheel_cnt < 2'h2) |=> wheel2_axis == '0)
    else $error("Wheel 2 acts while not fitted");
  second_field_a: assert property (@(posedge clk) disable iff (!rst_b) // (RL8)
    (mode_on && wheel_cnt >= 2'h2 && sel_ff[15] && sel_ff[12:8] == 5'h02) |=> wheel2_axis == 5'h02)
    else $error("Wheel 2 field misplaced");
  third_fit_a: assert property (@(posedge clk) disable iff (!rst_b) // (RL6)
    (wheel_cnt != 2'h3) |=> wheel3_axis == '0)
    else $error("Wheel 3 acts while not fitted");
  third_field_a: assert property (@(posedge clk) disable iff (!rst_b) // (RL9)
    (mode_on && wheel_cnt == 2'h3 && sel_ff[23] && sel_ff[20:16] == 5'h04)
      |=> wheel3_axis == 5'h04)
    else $error("Wheel 3 field misplaced");
  step_route_a: assert property (@(posedge clk) disable iff (!rst_b) // (RL4)
    (wheel_step[0] && nxt_axis[0] == 5'h01) |=> axis_step[0])
    else $error("Wheel 1 step not routed to first axis");
  step_cause_a: assert property (@(posedge clk) disable iff (!rst_b) // (RL3)
    (axis_step != '0) |-> $past(wheel_step != '0 && mode_on))
    else $error("Axis step without a handwheel step in mode");
  cover_step_c: cover property (@(posedge clk) disable iff (!rst_b) axis_step != '0);
  cover_three_c: cover property (@(posedge clk) disable iff (!rst_b) wheel3_axis != '0);
  cover_order_c: cover property (@(posedge clk) disable iff (!rst_b)
    w_hs && !aw_hs ##[1:4] aw_hs);
endmodule : hwas_selector
`default_nettype wire

/* File: dv/hwas_wheel_model.sv */
// Handwheel pulse generator model that turns a detent request into a step pulse one cycle later.
`timescale 1ns/100ps
`default_nettype none
module hwas_wheel_model
  import hwas_pkg::*;
(
  input  wire logic              clk,       // Scan clock.
  input  wire logic              rst_b,     // Asynchronous reset, active low.
  input  wire logic [WHEELS-1:0] turn,      // Detent request from the bench.
  output logic      [WHEELS-1:0] wheel_step // One pulse per detent, rests low.
);
  // The encoder front end registers each detent, so the line follows turn one cycle later, high as long as turn was.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wheel_step <= '0;
    end else begin
      wheel_step <= turn;
    end
  end
endmodule : hwas_wheel_model
`default_nettype wire

/* File: dv/hwas_selector_tb_top.sv */
// Self-checking bench for the handwheel axis selector over its register bus and step path.
`timescale 1ns/100ps
`default_nettype none
module hwas_selector_tb_top;
  import hwas_pkg::*;
  logic clk = 1'b0;           // 200 MHz clock.
  logic rst_b = 1'b0;         // Reset, active low.
  logic [3:0] awaddr = '0, araddr = '0, wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdat;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [WHEELS-1:0] turn = '0, wheel_step;
  logic [AXES-1:0] axis_step;
  logic [NUM_W-1:0] w1, w2, w3;
  logic [31:0] rdata_o;
  int fail_count = 0, checks_done = 0, cyc = 0, n;

  hwas_wheel_model hwas_wheel_model_i (.clk(clk), .rst_b(rst_b), .turn(turn),
    .wheel_step(wheel_step));
  hwas_selector hwas_selector_i (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata_o),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wheel_step(wheel_step), .axis_step(axis_step), .wheel1_axis(w1), .wheel2_axis(w2),
    .wheel3_axis(w3));

  // Free-running clock.
  initial begin
    forever #2.5 clk = ~clk;
  end

  // Prints the verdict and stops the run.
  task automatic final_report();
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  // Compares one value; four-state equality so an unknown never matches.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Write: readiness is judged at the falling edge, so release happens after the taking edge.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(negedge clk);
      aw_t = awvalid && awready; w_t = wvalid && wready; b_t = bvalid; resp = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 0;
      if (w_t) wvalid <= 0;
    end while (!b_t);
    bready <= 0;
  endtask : wr

  // Read: holds the request until taken and rready until the answer is sampled.
  task automatic rd(input logic [3:0] a);
    logic ar_t, r_t;
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(negedge clk);
      ar_t = arvalid && arready; r_t = rvalid; rdat = rdata_o; resp = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 0;
    end while (!r_t);
    rready <= 0;
  endtask : rd

  // One detent on the wheels in v; the design answers one edge after the model's pulse.
  task automatic step(input logic [WHEELS-1:0] v, input logic [AXES-1:0] exp);
    @(posedge clk); turn <= v;
    @(posedge clk); turn <= '0;
    @(posedge clk); #1;
    chk("axis_step", 32'(axis_step), 32'(exp));
  endtask : step

  // Lets the decoded axis outputs catch up with a selection write.
  task automatic settle();
    @(posedge clk); #1;
  endtask : settle

  // Cuts a hang short; the tests need well under a thousand cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_CTRL); chk("ctrl_reset", rdat, CTRL_RST);
    rd(ADDR_SEL); chk("sel_reset", rdat, SEL_RST);
    // An unmapped read answers zero with an error code.
    rd(4'hc); chk("unmapped_resp", 32'(resp), 32'(RESP_SLVERR));
    chk("unmapped_data", rdat, 32'h0);
    // mode first, then numbers and valid bits in one write; wheel 3 left invalid.
    wr(ADDR_CTRL, 32'h0000_0007);
    rd(ADDR_CTRL); chk("ctrl_readback", rdat, 32'h0000_0007);
    chk("ctrl_rd_resp", 32'(resp), 32'(RESP_OKAY));
    wr(ADDR_SEL, 32'h0003_8281);
    chk("sel_wr_resp", 32'(resp), 32'(RESP_OKAY));
    settle();
    chk("wheel1_axis", 32'(w1), 32'h1);
    chk("wheel2_axis", 32'(w2), 32'h2);
    chk("wheel3_axis", 32'(w3), 32'h0);
    // The status word mirrors the three selections and their active flags.
    rd(ADDR_STAT); chk("stat_word", rdat, 32'h0300_0201);
    chk("stat_rd_resp", 32'(resp), 32'(RESP_OKAY));
    step(3'b111, 8'h03);
    // Valid before number: nothing moves until the number arrives.
    wr(ADDR_SEL, 32'h0080_8281);
    step(3'b100, 8'h00);
    wr(ADDR_SEL, 32'h0084_8281);
    settle();
    chk("wheel3_axis", 32'(w3), 32'h4);
    step(3'b100, 8'h08);
    step(3'b010, 8'h02);
    // Two wheels fitted: the third wheel is ignored while the second still acts.
    wr(ADDR_CTRL, 32'h0000_0005);
    step(3'b110, 8'h02);
    // Every axis number in turn, and one past the last axis.
    for (n = 1; n <= AXES + 1; n++) begin
      wr(ADDR_SEL, 32'(n) | 32'h80);
      step(3'b001, (n <= AXES) ? 8'(1 << (n - 1)) : 8'h00);
    end
    // One wheel fitted: the second wheel is ignored.
    wr(ADDR_CTRL, 32'h0000_0003);
    wr(ADDR_SEL, 32'h0000_8281);
    step(3'b010, 8'h00);
    step(3'b001, 8'h01);
    // No wheel fitted: even the first wheel moves nothing.
    wr(ADDR_CTRL, 32'h0000_0001);
    step(3'b001, 8'h00);
    // Handle mode off: no axis selected, no pulse.
    wr(ADDR_CTRL, 32'h0000_0002);
    settle();
    chk("wheel1_axis", 32'(w1), 32'h0);
    step(3'b001, 8'h00);
    // The status word is read-only.
    wr(ADDR_STAT, 32'hffff_ffff);
    chk("stat_wr_resp", 32'(resp), 32'(RESP_SLVERR));
    final_report();
  end
endmodule : hwas_selector_tb_top
`default_nettype wire
